// file: timer_capture_irq.sv
// capture registers, flag/enable registers and apb slave for timers 1 and 3
// assumes: counter, comparators and waveform unit outside; index 0 is timer1
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`include "timer_capture_defs.svh"
module timer_capture_irq (
    input  wire logic                              mclk,              // i/o clock
    input  wire logic                              sys_rst,           // sync reset
    input  wire logic                              psel,              // apb select
    input  wire logic                              penable,           // apb enable
    input  wire logic                              pwrite,            // apb write
    input  wire logic [7:0]                        paddr,             // apb byte address
    input  wire logic [31:0]                       pwdata,            // apb write data
    output logic      [31:0]                       prdata,            // apb read data
    output logic                                   pready,            // apb ready
    output logic                                   pslverr,           // unmapped address
    input  wire logic [1:0]                        timer_tick,        // timer clock enables
    input  wire timer_capture_pkg::count_type [1:0] timer_count,      // counter values
    input  wire logic [1:0][2:0]                   compare_match,     // counter equals c,b,a
    input  wire logic [1:0]                        counter_wrap,      // overflow at tick
    input  wire logic [1:0]                        capture_input_pin, // capture pins
    input  wire logic                              comparator_out,    // analog comparator
    input  wire logic                              global_irq_en,     // cpu global enable
    input  wire logic [1:0][7:0]                   vector_ack,        // vector executed
    output timer_capture_pkg::count_type [1:0]     capture_value,     // capture words
    output logic      [1:0]                        capture_is_top,    // capture value is top
    output logic      [1:0][2:0]                   force_match,       // forced match strobes
    output logic      [1:0][7:0]                   timer_irq_req,     // per-source requests
    output logic                                   irq                // capture summary irq
);
    import timer_capture_pkg::*;

    logic [1:0][7:0] irq_enable, next_irq_enable, ctrl, next_ctrl, flags, clr_ones;
    logic [1:0][2:0] next_force;
    logic [1:0]      cap_wr, cap_evt, status, next_status, mask, next_mask, next_is_top;
    byte_type        temp_hi, next_temp_hi, held_hi, next_held_hi;
    count_type       cap_wdata;
    logic [31:0]     next_prdata;
    logic            next_pready, next_pslverr, next_irq, setup, done, tsel;
    reg_sel_type     sel;

    // register picked by an address
    function automatic reg_sel_type decode(input logic [7:0] a);
        reg_sel_type s;
        s = SEL_NONE;
        if (a[7:6] == 2'b00) begin
            case (a[4:0])
                `OFS_ENABLE: s = SEL_ENABLE;
                `OFS_FLAGS:  s = SEL_FLAGS;
                `OFS_CTRL:   s = SEL_CTRL;
                `OFS_CAP_LO: s = SEL_CAP_LO;
                `OFS_CAP_HI: s = SEL_CAP_HI;
                default:     s = SEL_NONE;
            endcase
        end else begin
            case (a)
                `OFS_FORCE:  s = SEL_FORCE;
                `OFS_STATUS: s = SEL_STATUS;
                `OFS_MASK:   s = SEL_MASK;
                default:     s = SEL_NONE;
            endcase
        end
        return s;
    endfunction

    // waveform modes that use the capture value as top
    function automatic logic top_mode(input logic [3:0] mode);
        return (mode == `MODE_TOP_CTC) || (mode == `MODE_TOP_PWM);
    endfunction

    // per-timer capture and flag logic
    for (genvar i = 0; i < 2; i++) begin : g_timer
        capture_unit u_cap (
            .mclk      (mclk),
            .sys_rst   (sys_rst),
            .tick      (timer_tick[i]),
            .pin       (capture_input_pin[i]),
            .acomp     (comparator_out),
            .src_sel   (ctrl[i][`CTRL_SRC]),
            .filter_en (ctrl[i][`CTRL_FILTER]),
            .edge_sel  (ctrl[i][`CTRL_EDGE]),
            .is_top    (capture_is_top[i]),
            .count     (timer_count[i]),
            .wr_en     (cap_wr[i]),
            .wr_data   (cap_wdata),
            .value     (capture_value[i]),
            .event_q   (cap_evt[i])
        );
        irq_flag_unit u_flag (
            .mclk     (mclk),
            .sys_rst  (sys_rst),
            .tick     (timer_tick[i]),
            .match    (compare_match[i]),
            .wrap     (counter_wrap[i]),
            .capture  (cap_evt[i]),
            .vec_ack  (vector_ack[i]),
            .clr_ones (clr_ones[i]),
            .enable   (irq_enable[i]),
            .gie      (global_irq_en),
            .flags    (flags[i]),
            .irq_req  (timer_irq_req[i])
        );
    end

    // apb phases: answer at the first access cycle, effects at completion
    assign setup = psel && !penable;
    assign done  = psel && penable && pready;
    assign sel   = decode(paddr);
    assign tsel  = paddr[`TIMER_SEL_BIT];

    // register file next values
    always_comb begin
        next_pready     = setup;
        next_pslverr    = setup && (sel == SEL_NONE);
        next_prdata     = setup ? 32'h0000_0000 : prdata;
        next_held_hi    = held_hi;
        next_temp_hi    = temp_hi;
        next_irq_enable = irq_enable;
        next_ctrl       = ctrl;
        next_mask       = mask;
        next_status     = status | cap_evt;
        next_force      = '0;
        clr_ones        = '0;
        cap_wr          = 2'b00;
        cap_wdata       = {temp_hi, pwdata[7:0]};
        if (setup && !pwrite) begin
            case (sel)
                SEL_ENABLE: next_prdata[7:0] = irq_enable[tsel];
                SEL_FLAGS:  next_prdata[7:0] = flags[tsel];
                SEL_CTRL:   next_prdata[7:0] = ctrl[tsel];
                SEL_CAP_LO: begin
                    next_prdata[7:0] = capture_value[tsel][7:0];
                    next_held_hi     = capture_value[tsel][15:8];
                end
                SEL_CAP_HI: next_prdata[7:0] = temp_hi;
                SEL_STATUS: next_prdata[1:0] = status;
                SEL_MASK:   next_prdata[1:0] = mask;
                default:    next_prdata = 32'h0000_0000;  // force and unmapped
            endcase
        end
        if (done && pwrite) begin
            case (sel)
                SEL_ENABLE: next_irq_enable[tsel] = pwdata[7:0] & `IRQ_REG_MASK;
                SEL_FLAGS:  clr_ones[tsel] = pwdata[7:0] & `IRQ_REG_MASK;
                SEL_CTRL:   next_ctrl[tsel] = pwdata[7:0]
                                & (tsel ? `CTRL_MASK_T3 : `CTRL_MASK_T1);
                SEL_CAP_LO: cap_wr[tsel] = 1'b1;
                SEL_CAP_HI: next_temp_hi = pwdata[7:0];
                // strobes go to the waveform unit only, never to flags
                SEL_FORCE: begin
                    next_force[0] = pwdata[2:0];
                    next_force[1] = pwdata[`FORCE_T3_LSB+2:`FORCE_T3_LSB];
                end
                SEL_MASK:   next_mask = pwdata[1:0];
                default:    next_mask = mask;
            endcase
        end
        if (done && !pwrite) begin
            if (sel == SEL_CAP_LO)
                next_temp_hi = held_hi;
            if (sel == SEL_STATUS)
                next_status = (status & ~prdata[1:0]) | cap_evt;
        end
        for (int i = 0; i < 2; i++)
            next_is_top[i] = top_mode(next_ctrl[i][3:0]);
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata         <= 32'h0000_0000;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            irq_enable     <= {`REG_RESET, `REG_RESET};
            ctrl           <= {`REG_RESET, `REG_RESET};
            temp_hi        <= 8'h00;
            held_hi        <= 8'h00;
            status         <= 2'b00;
            mask           <= 2'b00;
            capture_is_top <= 2'b00;
            force_match    <= '0;
            irq            <= 1'b0;
        end else begin
            prdata         <= next_prdata;
            pready         <= next_pready;
            pslverr        <= next_pslverr;
            irq_enable     <= next_irq_enable;
            ctrl           <= next_ctrl;
            temp_hi        <= next_temp_hi;
            held_hi        <= next_held_hi;
            status         <= next_status;
            mask           <= next_mask;
            capture_is_top <= next_is_top;
            force_match    <= next_force;
            irq            <= next_irq;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_temp_coherent: assert property (setup && !pwrite && sel == SEL_CAP_LO && !tsel
        ##1 done |=> temp_hi == $past(capture_value[0][15:8], 2))
        else $error("high latch does not hold high byte of low read");
    a_enable_rsvd: assert property (((irq_enable[0] | irq_enable[1]) & ~`IRQ_REG_MASK) == 8'h00)
        else $error("reserved enable bit set");
    a_top_follows: assert property (capture_is_top[0] == top_mode(ctrl[0][3:0]))
        else $error("top select disagrees with waveform mode");
    a_w1c_flag: assert property (done && pwrite && sel == SEL_FLAGS && !tsel && pwdata[`BIT_WRAP]
        && !(timer_tick[0] && counter_wrap[0]) |=> !flags[0][`BIT_WRAP])
        else $error("wrap flag not cleared by writing one");
endmodule // timer_capture_irq

// file: timer_capture_defs.svh
// offsets, field positions, reset values and timing counts of the capture block
// assumes: included by bare name from each design module
// Summary of operation
// - capture event copies counter into capture value; timer1 may use comparator
// - 16-bit capture value read coherently through shared 8-bit high latch
// - capture value may serve as counter top in the matching waveform modes
// - enable register: capture bit5, match c/b/a bits3..1, wrap bit0
// - request while flag set, its enable set and global enable set
// - capture flag sets on each selected edge of the capture source, after the filter when on, while capture value is not top
// - in capture-top modes capture flag sets when counter reaches top
// - flags clear on vector execution or software write of one
// - match flag sets one timer tick after counter equals compare value
// - forced match strobes never touch match flags
// - wrap flag sets on counter overflow reported by the counter
// - flag register: capture bit5, match c/b/a bits3..1, wrap bit0
// - edge select zero picks falling edge, one picks rising edge
// - filter needs four equal samples, delaying capture four cycles
// - capture pin disconnected while capture value is top
`ifndef TIMER_CAPTURE_DEFS_SVH
`define TIMER_CAPTURE_DEFS_SVH
// per-timer block offsets, address bit 5 picks timer3
`define OFS_ENABLE     5'h00
`define OFS_FLAGS      5'h04
`define OFS_CTRL       5'h08
`define OFS_CAP_LO     5'h0C
`define OFS_CAP_HI     5'h10
`define TIMER_SEL_BIT  5
// common registers
`define OFS_FORCE      8'h40
`define OFS_STATUS     8'h44
`define OFS_MASK       8'h48
// flag and enable layout
`define BIT_CAPTURE    5
`define BIT_MATCH_C    3
`define BIT_MATCH_B    2
`define BIT_MATCH_A    1
`define BIT_WRAP       0
`define IRQ_REG_MASK   8'h2F
`define REG_RESET      8'h00
// control register layout
`define CTRL_FILTER    7
`define CTRL_EDGE      6
`define CTRL_SRC       5
`define CTRL_MASK_T1   8'hEF
`define CTRL_MASK_T3   8'hCF
`define MODE_TOP_CTC   4'hC
`define MODE_TOP_PWM   4'hE
// force register: timer3 strobes sit this far above timer1
`define FORCE_T3_LSB   4
// noise filter sample count
`define FILTER_LEN     4
`endif

// file: timer_capture_pkg.sv
// types shared by the timer capture and interrupt flag block
// assumes: compiled before the design modules
package timer_capture_pkg;
    // register picked by an apb address
    typedef enum logic [3:0] {SEL_NONE, SEL_ENABLE, SEL_FLAGS, SEL_CTRL, SEL_CAP_LO,
                              SEL_CAP_HI, SEL_FORCE, SEL_STATUS, SEL_MASK} reg_sel_type;
    typedef logic [15:0] count_type;   // counter and capture word
    typedef logic [7:0]  byte_type;    // one register byte
endpackage

// file: capture_unit.sv
// input capture of one timer: source select, filter, edge detect, capture word
// assumes: pin, comparator and counter synchronous to mclk
`timescale 1ns/1ns
`include "timer_capture_defs.svh"
module capture_unit (
    input  wire logic                       mclk,      // i/o clock
    input  wire logic                       sys_rst,   // sync reset
    input  wire logic                       tick,      // timer clock enable
    input  wire logic                       pin,       // capture input pin
    input  wire logic                       acomp,     // comparator output
    input  wire logic                       src_sel,   // 1: comparator source
    input  wire logic                       filter_en, // noise filter on
    input  wire logic                       edge_sel,  // 1: rising edge
    input  wire logic                       is_top,    // capture value is top
    input  wire timer_capture_pkg::count_type count,   // counter value
    input  wire logic                       wr_en,     // software write
    input  wire timer_capture_pkg::count_type wr_data, // written word
    output timer_capture_pkg::count_type    value,     // capture value
    output logic                            event_q    // capture flag set pulse
);
    import timer_capture_pkg::*;

    logic [`FILTER_LEN-2:0] hist, next_hist;
    logic      raw, sig, filt_q, next_filt, prev_q, edge_hit, top_hit, next_event;
    count_type next_value;

    // source, filtered or raw level, edge and top hit
    assign raw      = src_sel ? acomp : pin;
    assign sig      = filter_en ? filt_q : raw;
    assign edge_hit = !is_top
                      && (edge_sel ? (sig && !prev_q) : (!sig && prev_q));
    assign top_hit  = is_top && tick && (count == value);

    always_comb begin
        next_hist = {hist[`FILTER_LEN-3:0], raw};
        next_filt = filt_q;
        if (!filter_en)
            next_filt = raw;
        else if (&{hist, raw})
            next_filt = 1'b1;
        else if (~|{hist, raw})
            next_filt = 1'b0;
        next_value = value;
        if (wr_en)
            next_value = wr_data;
        else if (edge_hit)
            next_value = count;
        next_event = edge_hit || top_hit;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hist    <= '0;
            filt_q  <= 1'b0;
            prev_q  <= 1'b0;
            value   <= 16'h0000;
            event_q <= 1'b0;
        end else begin
            hist    <= next_hist;
            filt_q  <= next_filt;
            prev_q  <= sig;
            value   <= next_value;
            event_q <= next_event;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_capture_copy: assert property (edge_hit && !wr_en |=> value == $past(count))
        else $error("capture value differs from counter at event");
    a_pin_gated: assert property (is_top && !wr_en && !top_hit |=> value == $past(value))
        else $error("capture value changed while used as top");
    a_filter_four: assert property (filter_en && raw && $past(raw) && $past(raw, 2)
        && $past(raw, 3) |=> filt_q)
        else $error("filter output not high after four samples");
endmodule // capture_unit

// file: irq_flag_unit.sv
// flag register and interrupt requests of one timer
// assumes: match and wrap levels come from the counter, valid at ticks
`timescale 1ns/1ns
`include "timer_capture_defs.svh"
module irq_flag_unit (
    input  wire logic       mclk,      // i/o clock
    input  wire logic       sys_rst,   // sync reset
    input  wire logic       tick,      // timer clock enable
    input  wire logic [2:0] match,     // counter equals compare c,b,a
    input  wire logic       wrap,      // counter overflow this tick
    input  wire logic       capture,   // capture event pulse
    input  wire logic [7:0] vec_ack,   // vector executed, flag layout
    input  wire logic [7:0] clr_ones,  // software ones to clear
    input  wire logic [7:0] enable,    // interrupt enable register
    input  wire logic       gie,       // global interrupt enable
    output logic      [7:0] flags,     // flag register
    output logic      [7:0] irq_req    // per-source requests
);
    logic [2:0] match_q, next_match_q;
    logic [7:0] set, next_flags, next_irq;

    // match seen at one tick sets its flag at the next tick
    always_comb begin
        set          = 8'h00;
        next_match_q = match_q;
        if (tick) begin
            next_match_q       = match;
            set[`BIT_MATCH_A]  = match_q[0];
            set[`BIT_MATCH_B]  = match_q[1];
            set[`BIT_MATCH_C]  = match_q[2];
            set[`BIT_WRAP]     = wrap;
        end
        set[`BIT_CAPTURE] = capture;
        // set wins over clear, zero writes keep the flag
        next_flags = ((flags & ~(vec_ack | clr_ones)) | set) & `IRQ_REG_MASK;
        next_irq   = next_flags & enable & {8{gie}};
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            match_q <= 3'h0;
            flags   <= `REG_RESET;
            irq_req <= 8'h00;
        end else begin
            match_q <= next_match_q;
            flags   <= next_flags;
            irq_req <= next_irq;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_match_delay: assert property (tick && match_q[0] |=> flags[`BIT_MATCH_A])
        else $error("match a flag not set one tick after match");
    a_set_wins: assert property (capture |=> flags[`BIT_CAPTURE])
        else $error("capture flag lost against a clear");
    a_ack_clears: assert property (vec_ack[`BIT_WRAP] && !(tick && wrap) |=> !flags[`BIT_WRAP])
        else $error("wrap flag survived its vector");
    a_req_gated: assert property (irq_req[`BIT_CAPTURE] |-> flags[`BIT_CAPTURE]
        && $past(enable[`BIT_CAPTURE]) && $past(gie))
        else $error("capture request without flag and enables");
endmodule // irq_flag_unit

// file: cpu_irq_model.sv
// cpu interrupt controller model: executes one pending vector at a time
// assumes: requests are levels in flag layout, acks are one-cycle pulses
`timescale 1ns/1ns
module cpu_irq_model (
    input  wire logic            mclk,    // i/o clock
    input  wire logic            sys_rst, // sync reset
    input  wire logic            ack_on,  // vector execution allowed
    input  wire logic [1:0][7:0] req,     // per-source requests
    output logic      [1:0][7:0] ack      // vector executed pulses
);
    // lowest pending source of timer1 first, then timer3; idle a cycle after each
    always @(posedge mclk) begin
        ack <= '0;
        if (!sys_rst && ack_on && ack == '0) begin
            if (req[0] != 8'h00)
                ack[0] <= req[0] & (~req[0] + 8'h01);
            else if (req[1] != 8'h00)
                ack[1] <= req[1] & (~req[1] + 8'h01);
        end
    end
endmodule // cpu_irq_model

// file: timer_capture_irq_tb.sv
// self-checking bench of the capture and interrupt flag block
// assumes: apb answer after one access cycle, timer ticks held on
`timescale 1ns/1ns
module timer_capture_irq_tb;
    import timer_capture_pkg::*;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, comparator_out;
    logic global_irq_en, irq, ack_on;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata;
    logic [1:0]        timer_tick, counter_wrap, capture_input_pin, capture_is_top;
    count_type [1:0]   timer_count, capture_value;
    logic [1:0][2:0]   compare_match, force_match;
    logic [1:0][7:0]   vector_ack, timer_irq_req;
    logic [32:0]       expq[$];
    int                error_cnt, tests_run;
    logic [15:0]       cnt;
    logic [5:0]        force_seen;
    timer_capture_irq dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_tick(timer_tick), .timer_count(timer_count),
        .compare_match(compare_match), .counter_wrap(counter_wrap),
        .capture_input_pin(capture_input_pin), .comparator_out(comparator_out),
        .global_irq_en(global_irq_en), .vector_ack(vector_ack),
        .capture_value(capture_value), .capture_is_top(capture_is_top),
        .force_match(force_match), .timer_irq_req(timer_irq_req), .irq(irq));
    cpu_irq_model cpu (.mclk(mclk), .sys_rst(sys_rst), .ack_on(ack_on),
        .req(timer_irq_req), .ack(vector_ack));
    // clock of 100 ns
    always #50 mclk = ~mclk;
    task check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task tk(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
        // idle edge, so a following call never reassigns psel in this step
        @(posedge mclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    // note expected {pslverr, prdata}, then read
    task rd(input logic [7:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask
    // compare each completed read against the oldest note
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
            check({pslverr, prdata}, expq.pop_front());
    end
    // remember the last forced match strobes of both timers
    always @(posedge mclk) begin
        if (sys_rst)
            force_seen <= '0;
        else if (force_match != '0)
            force_seen <= force_match;
    end
    // hang guard
    initial begin
        tk(3000);
        error_cnt++;
        stop_test();
    end
    initial begin
        {mclk, psel, penable, pwrite, paddr, pwdata, comparator_out, ack_on} = '0;
        {counter_wrap, capture_input_pin, timer_count, compare_match} = '0;
        {global_irq_en, error_cnt, tests_run} = '0;
        sys_rst = 1'b1;
        timer_tick = 2'b11;
        tk(5);
        sys_rst <= 1'b0;
        void'($urandom(95862));
        rd(8'h00, 33'h0);
        rd(8'h24, 33'h0);
        wr(8'h00, 32'hFF);
        rd(8'h00, 33'h2F);
        rd(8'h14, 33'h1_0000_0000); // unmapped place
        $display("done: registers");
        compare_match[0] <= 3'b111;
        tk(1);
        compare_match[0] <= 3'b000;
        tk(2);
        rd(8'h04, 33'h0E);
        wr(8'h40, 32'h77);
        rd(8'h04, 33'h0E);
        check(force_seen, 33'h3F);
        wr(8'h04, 32'h00);
        rd(8'h04, 33'h0E);
        wr(8'h04, 32'h02);
        rd(8'h04, 33'h0C);
        wr(8'h04, 32'h0C);
        $display("done: match flags");
        counter_wrap[0] <= 1'b1;
        global_irq_en <= 1'b1;
        tk(1);
        counter_wrap[0] <= 1'b0;
        tk(2);
        check(timer_irq_req[0], 33'h01);
        global_irq_en <= 1'b0;
        tk(2);
        check(timer_irq_req[0], 33'h00);
        global_irq_en <= 1'b1;
        ack_on <= 1'b1;
        tk(4);
        rd(8'h04, 33'h0);
        ack_on <= 1'b0;
        $display("done: wrap and vectors");
        wr(8'h08, 32'h40);
        cnt = 16'($urandom);
        timer_count[0] <= cnt;
        capture_input_pin[0] <= 1'b1;
        tk(4);
        check(capture_value[0], 33'(cnt));
        rd(8'h04, 33'h20);
        rd(8'h0C, 33'(cnt[7:0]));
        rd(8'h10, 33'(cnt[15:8]));
        wr(8'h48, 32'h01);
        tk(2);
        check(irq, 33'h1);
        rd(8'h44, 33'h01);
        tk(2);
        check(irq, 33'h0);
        timer_count[0] <= ~cnt;
        capture_input_pin[0] <= 1'b0;
        tk(8);
        check(capture_value[0], 33'(cnt));
        wr(8'h10, 32'hA5);
        wr(8'h0C, 32'h5A);
        check(capture_value[0], 33'hA55A);
        $display("done: capture");
        wr(8'h08, 32'hC0);
        timer_count[0] <= cnt + 16'h0001;
        capture_input_pin[0] <= 1'b1;
        tk(2);
        timer_count[0] <= cnt + 16'h0002;
        tk(10);
        check(capture_value[0], 33'(cnt + 16'h0002));
        // keep the counter off the capture value so no top hit sets the flag yet
        timer_count[0] <= cnt + 16'h0003;
        wr(8'h04, 32'h20);
        wr(8'h08, 32'h4C);
        check(capture_is_top[0], 33'h1);
        capture_input_pin[0] <= 1'b0;
        tk(3);
        capture_input_pin[0] <= 1'b1;
        tk(4);
        check(capture_value[0], 33'(cnt + 16'h0002));
        rd(8'h04, 33'h0);
        timer_count[0] <= cnt + 16'h0002;
        tk(3);
        rd(8'h04, 33'h20);
        $display("done: filter and top");
        tk(2);
        stop_test();
    end
endmodule // timer_capture_irq_tb
